// ===== sdt_timer.sv
// split dual 8-bit down-counter timer with its byte-wide register set
// assumes a single-cycle register port on the same clock; debugHalt is synchronous
`timescale 1ns/1ns
module sdt_timer
  import sdt_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [5:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // system
  input wire logic debugHalt,
  // status outputs
  output logic [NUM_CMP-1:0] lowCompareOut,
  output logic [NUM_CMP-1:0] highIrqSpare,
  output logic irqLine
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrlA;
  logic splitEnable;
  logic [1:0] commandTargetSelect;
  logic [7:0] splitInterruptEnable;
  logic [7:0] splitInterruptFlags;
  logic runWhenHalted;
  logic [7:0] lowCount;
  logic [7:0] highCount;
  logic [7:0] lowPeriod;
  logic [7:0] highPeriod;
  logic [7:0] lowCompareChannelValue [NUM_CMP];
  logic [9:0] prescaleCnt;
  logic tick;
  logic running;
  logic hardReset;
  logic restart;
  logic wrClr;
  logic wrSet;
  logic [1:0] cmdWritten;
  logic [1:0] next_target;
  logic lowUnder;
  logic highUnder;
  logic [NUM_CMP-1:0] lowMatch;
  logic [7:0] flagSet;

  assign wrClr = regWrite && regAddr == OFS_CMDCLR;
  assign wrSet = regWrite && regAddr == OFS_CMDSET;
  assign cmdWritten = regWdata[3:2];
  // ****************************************
  // command decode
  // ****************************************
  // command only acts from the set register, with both halves selected
  assign restart = wrSet && cmdWritten == CMD_RESTART && regWdata[1:0] == TGT_BOTH;
  assign hardReset = wrSet && cmdWritten == CMD_RESET && regWdata[1:0] == TGT_BOTH
    && !ctrlA[CTRLA_EN];
  assign running = ctrlA[CTRLA_EN] && splitEnable && (runWhenHalted || !debugHalt);

  always_comb begin
    next_target = commandTargetSelect;
    if (wrClr) begin
      next_target = commandTargetSelect & ~regWdata[1:0];
    end else if (wrSet) begin
      next_target = commandTargetSelect | regWdata[1:0];
    end
  end

  // ****************************************
  // prescaler
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_n || hardReset || restart || !running) begin
      prescaleCnt <= 10'h000;
    end else begin
      prescaleCnt <= prescaleCnt + 10'h001;
    end
  end

  always_comb begin
    case (ctrlA[CTRLA_CLKSEL_HI:CTRLA_CLKSEL_LO])
      3'h0: tick = 1'b1;
      3'h1: tick = prescaleCnt[0:0] == 1'h1;
      3'h2: tick = prescaleCnt[1:0] == 2'h3;
      3'h3: tick = prescaleCnt[2:0] == 3'h7;
      3'h4: tick = prescaleCnt[3:0] == 4'hF;
      3'h5: tick = prescaleCnt[5:0] == 6'h3F;
      3'h6: tick = prescaleCnt[7:0] == 8'hFF;
      default: tick = prescaleCnt == 10'h3FF;
    endcase
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_n || hardReset) begin
      ctrlA <= ZERO8;
      splitEnable <= 1'b0;
      commandTargetSelect <= 2'h0;
      splitInterruptEnable <= ZERO8;
      runWhenHalted <= 1'b0;
      lowPeriod <= PER_RESET;
      highPeriod <= PER_RESET;
    end else begin
      commandTargetSelect <= next_target;
      if (regWrite) begin
        case (regAddr)
          OFS_CTRLA: ctrlA <= regWdata & CTRLA_MASK;
          OFS_SPLIT: splitEnable <= regWdata[0];
          OFS_INTEN: splitInterruptEnable <= regWdata & INT_MASK;
          OFS_DBG: runWhenHalted <= regWdata[0];
          OFS_LOW_TOP: lowPeriod <= regWdata;
          OFS_HIGH_TOP: highPeriod <= regWdata;
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // compare registers and comparators
  // ****************************************
  for (genvar n = 0; n < NUM_CMP; n++) begin : gCmp
    always_ff @(posedge clock) begin
      if (!rst_n || hardReset) begin
        lowCompareChannelValue[n] <= ZERO8;
      end else if (regWrite && regAddr == OFS_LOW_CMP + 6'(n) * OFS_CMP_STEP) begin
        lowCompareChannelValue[n] <= regWdata;
      end
    end
    assign lowMatch[n] = splitEnable && lowCount == lowCompareChannelValue[n];
    assign flagSet[FLG_LOW_CMP+n] = lowMatch[n];
  end

  // ****************************************
  // counters
  // ****************************************
  assign lowUnder = running && tick && lowCount == ZERO8;
  assign highUnder = running && tick && highCount == ZERO8;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lowCount <= ZERO8;
    end else if (regWrite && regAddr == OFS_LOW_CNT) begin
      lowCount <= regWdata;
    end else if (hardReset || restart) begin
      lowCount <= ZERO8;
    end else if (lowUnder) begin
      lowCount <= lowPeriod;
    end else if (running && tick) begin
      lowCount <= lowCount - 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      highCount <= ZERO8;
    end else if (regWrite && regAddr == OFS_HIGH_CNT) begin
      highCount <= regWdata;
    end else if (hardReset || restart) begin
      highCount <= ZERO8;
    end else if (highUnder) begin
      highCount <= highPeriod;
    end else if (running && tick) begin
      highCount <= highCount - 8'h01;
    end
  end

  // ****************************************
  // flags
  // ****************************************
  assign flagSet[FLG_LOW_UNDER] = lowUnder;
  assign flagSet[FLG_HIGH_UNDER] = highUnder;
  assign flagSet[3:2] = 2'h0;
  assign flagSet[7] = 1'b0;

  always_ff @(posedge clock) begin
    if (!rst_n || hardReset) begin
      splitInterruptFlags <= ZERO8;
    end else if (regWrite && regAddr == OFS_INTFLG) begin
      // set wins over a simultaneous clear
      splitInterruptFlags <= ((splitInterruptFlags & ~regWdata) | flagSet) & INT_MASK;
    end else begin
      splitInterruptFlags <= (splitInterruptFlags | flagSet) & INT_MASK;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lowCompareOut <= '0;
      highIrqSpare <= '0;
      irqLine <= 1'b0;
    end else begin
      lowCompareOut <= lowMatch;
      highIrqSpare <= '0;
      irqLine <= |(splitInterruptFlags & splitInterruptEnable);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regRdata <= ZERO8;
    end else if (regRead) begin
      case (regAddr)
        OFS_CTRLA: regRdata <= ctrlA;
        OFS_SPLIT: regRdata <= {7'h00, splitEnable};
        OFS_CMDCLR: regRdata <= {6'h00, commandTargetSelect};
        OFS_CMDSET: regRdata <= {6'h00, commandTargetSelect};
        OFS_INTEN: regRdata <= splitInterruptEnable;
        OFS_INTFLG: regRdata <= splitInterruptFlags;
        OFS_DBG: regRdata <= {7'h00, runWhenHalted};
        OFS_LOW_CNT: regRdata <= lowCount;
        OFS_HIGH_CNT: regRdata <= highCount;
        OFS_LOW_TOP: regRdata <= lowPeriod;
        OFS_HIGH_TOP: regRdata <= highPeriod;
        OFS_LOW_CMP: regRdata <= lowCompareChannelValue[0];
        OFS_LOW_CMP + OFS_CMP_STEP: regRdata <= lowCompareChannelValue[1];
        OFS_LOW_CMP + OFS_CMP_STEP + OFS_CMP_STEP: regRdata <= lowCompareChannelValue[2];
        default: regRdata <= ZERO8;
      endcase
    end
  end

endmodule

// ===== sdt_pkg.sv
// register offsets, field positions and command codes of the split dual timer
// assumes an 8-bit peripheral register port with byte addresses
package sdt_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [5:0] OFS_CTRLA = 6'h00;
  localparam logic [5:0] OFS_SPLIT = 6'h03;
  localparam logic [5:0] OFS_CMDCLR = 6'h04;
  localparam logic [5:0] OFS_CMDSET = 6'h05;
  localparam logic [5:0] OFS_INTEN = 6'h0A;
  localparam logic [5:0] OFS_INTFLG = 6'h0B;
  localparam logic [5:0] OFS_DBG = 6'h0E;
  localparam logic [5:0] OFS_LOW_CNT = 6'h20;
  localparam logic [5:0] OFS_HIGH_CNT = 6'h21;
  localparam logic [5:0] OFS_LOW_TOP = 6'h26;
  localparam logic [5:0] OFS_HIGH_TOP = 6'h27;
  localparam logic [5:0] OFS_LOW_CMP = 6'h28;
  localparam logic [5:0] OFS_CMP_STEP = 6'h02;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRLA_EN = 0;
  localparam int CTRLA_CLKSEL_LO = 1;
  localparam int CTRLA_CLKSEL_HI = 3;
  localparam int CTRLA_RUNSTBY = 7;
  localparam logic [7:0] CTRLA_MASK = 8'h8F;
  localparam logic [7:0] INT_MASK = 8'h73;
  localparam int FLG_LOW_UNDER = 0;
  localparam int FLG_HIGH_UNDER = 1;
  localparam int FLG_LOW_CMP = 4;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;
  localparam logic [1:0] TGT_BOTH = 2'h3;
  localparam logic [7:0] PER_RESET = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int NUM_CMP = 3;

endpackage

// ===== sdt_timer_monitor.sv
// checker for the split dual timer register port
// assumes it is bound to sdt_timer
`timescale 1ns/1ns
module sdt_timer_monitor
  import sdt_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [5:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // status
  input wire logic irqLine
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence wrRd(a);
    regWrite && regAddr == a ##1 regRead && regAddr == a;
  endsequence
  property backP(a, m);
    wrRd(a) |=> regRdata == ($past(regWdata, 2) & m);
  endproperty
  chk_low_byte_top_value_back: assert property (backP(OFS_LOW_TOP, 8'hFF))
    else $error("low period readback");
  chk_high_period_back: assert property (backP(OFS_HIGH_TOP, 8'hFF))
    else $error("high period readback");
  chk_inten_back: assert property (backP(OFS_INTEN, INT_MASK))
    else $error("enable readback");
  chk_low_byte_counter_value_wins: assert property (backP(OFS_LOW_CNT, 8'hFF))
    else $error("low count write lost");
  chk_high_byte_counter_value_wins: assert property (backP(OFS_HIGH_CNT, 8'hFF))
    else $error("high count write lost");
  chk_unmapped_zero: assert property (regRead && regAddr == 6'h06 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_cmd_zero: assert property (regRead && regAddr[5:1] == 5'h02 |=> regRdata[3:2] == 2'h0)
    else $error("command field read back");
  chk_flag_sticky: assert property (irqLine && !regWrite && !$past(regWrite) |=> irqLine)
    else $error("flag cleared by itself");
endmodule

// ===== test_sdt_timer.sv
// self-checking bench for the split dual timer
// assumes sdt_pkg, sdt_timer and the monitor are compiled first
`timescale 1ns/1ns
module test_sdt_timer
  import sdt_pkg::*;
;
  logic clock = 0;
  logic rst_n = 0;
  logic [5:0] regAddr = 6'h00;
  logic regWrite = 0;
  logic regRead = 0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic debugHalt = 0;
  logic [NUM_CMP-1:0] lowCompareOut;
  logic [NUM_CMP-1:0] highIrqSpare;
  logic irqLine;
  logic [7:0] a;
  logic [7:0] b;
  int errTotal = 0;
  int testsRun = 0;
  logic [15:0] rv [12] = '{16'h0300, 16'h0400, 16'h0500, 16'h0A00, 16'h0B00, 16'h0E00,
    16'h2000, 16'h2100, 16'h26FF, 16'h27FF, 16'h0600, 16'h2800};
  logic [23:0] su [8] = '{24'h280202, 24'h2A0303, 24'h2C0909, 24'h260505,
    24'h270303, 24'h0A8F03, 24'h03FF01, 24'h0EFE00};
  sdt_timer DUT (.clock, .rst_n, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
    .debugHalt, .lowCompareOut, .highIrqSpare, .irqLine);
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    testsRun++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    regRead = 0;
    regAddr = ad;
    regWdata = d;
    regWrite = 1;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [5:0] ad, output logic [7:0] d);
    regWrite = 0;
    regAddr = ad;
    regRead = 1;
    @(posedge clock);
    #1;
    d = regRdata;
  endtask
  task automatic idle;
    regWrite = 0;
    regRead = 0;
    @(posedge clock);
    #1;
  endtask
  task automatic rc(input logic [5:0] ad, input logic [7:0] e);
    logic [7:0] d;
    rd(ad, d);
    chk(d, e);
  endtask
  task automatic stopTest;
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  always #2 clock = ~clock;
  initial begin
    #4000;
    errTotal++;
    stopTest;
  end
  initial begin
    repeat (5) @(posedge clock);
    #1 rst_n = 1;
    foreach (rv[i]) rc(rv[i][13:8], rv[i][7:0]);
    $display("test 1 done");
    foreach (su[i]) begin
      wr(su[i][21:16], su[i][15:8]);
      rc(su[i][21:16], su[i][7:0]);
    end
    $display("test 2 done");
    wr(OFS_CTRLA, 8'h01);
    idle;
    #80;
    rc(OFS_INTFLG, 8'h33);
    chk({7'h00, irqLine}, 8'h01);
    wr(OFS_LOW_CNT, 8'h04);
    rc(OFS_LOW_CNT, 8'h04);
    wr(OFS_HIGH_CNT, 8'h02);
    rc(OFS_HIGH_CNT, 8'h02);
    debugHalt = 1;
    rd(OFS_LOW_CNT, a);
    rd(OFS_LOW_CNT, b);
    chk(b, a);
    wr(OFS_DBG, 8'h01);
    rd(OFS_LOW_CNT, a);
    rd(OFS_LOW_CNT, b);
    chk({7'h00, a !== b}, 8'h01);
    debugHalt = 0;
    $display("test 3 done");
    wr(OFS_CTRLA, 8'h00);
    wr(OFS_INTFLG, 8'h01);
    rc(OFS_INTFLG, 8'h32);
    chk({7'h00, irqLine}, 8'h01);
    wr(OFS_INTFLG, 8'h02);
    rc(OFS_INTFLG, 8'h30);
    chk({7'h00, irqLine}, 8'h00);
    wr(OFS_LOW_CNT, 8'h02);
    idle;
    chk({5'h00, lowCompareOut}, 8'h01);
    chk({5'h00, highIrqSpare}, 8'h00);
    $display("test 4 done");
    wr(OFS_LOW_CNT, 8'h55);
    wr(OFS_HIGH_CNT, 8'h66);
    wr(OFS_CMDSET, 8'h0B);
    rc(OFS_LOW_CNT, 8'h00);
    rc(OFS_HIGH_CNT, 8'h00);
    rc(OFS_LOW_TOP, 8'h05);
    rc(OFS_CMDSET, 8'h03);
    wr(OFS_CMDCLR, 8'h01);
    rc(OFS_CMDCLR, 8'h02);
    wr(OFS_CTRLA, 8'h01);
    wr(OFS_CMDSET, 8'h0F);
    rc(OFS_LOW_TOP, 8'h05);
    wr(OFS_CTRLA, 8'h00);
    wr(OFS_CMDCLR, 8'h03);
    wr(OFS_CMDSET, 8'h0C);
    rc(OFS_LOW_TOP, 8'h05);
    wr(OFS_CMDSET, 8'h0F);
    rc(OFS_LOW_TOP, 8'hFF);
    rc(OFS_INTEN, 8'h00);
    rc(OFS_SPLIT, 8'h00);
    $display("test 5 done");
    stopTest;
  end
endmodule
bind sdt_timer sdt_timer_monitor mon (.clock, .rst_n, .regAddr, .regWrite, .regRead,
  .regWdata, .regRdata, .irqLine);
